// ==== common/power_mux_map.vh ====
`ifndef POWER_MUX_MAP_VH
`define POWER_MUX_MAP_VH

// Clock rate and timing figures.
`define CLK_MHZ             100
`define SETTLE_US           10
`define SETTLE_CYC          (`SETTLE_US * `CLK_MHZ)
`define FILTER_MS           5
`define FILTER_CYC          (`FILTER_MS * 1000 * `CLK_MHZ)
`define FILTER_W            20

// Enable code decode.
`define MODE_AUTO           2'b00
`define MODE_NONE           2'b01
`define MODE_FORCE_A        2'b10
`define MODE_FORCE_B        2'b11

// APB register byte offsets.
`define REG_STATUS          12'h000
`define REG_IRQ_STATUS      12'h004
`define REG_IRQ_ENABLE      12'h008
`define REG_IRQ_CLEAR       12'h00c
`define REG_CONTROL         12'h010

// Status register fields.
`define ST_SEL_A            0
`define ST_SEL_B            1
`define ST_HEALTH_A         2
`define ST_HEALTH_B         3
`define ST_OVERTEMP         4
`define ST_LIMIT_A          5
`define ST_LIMIT_B          6
`define ST_MODE_LO          8
`define ST_MODE_HI          9

// Interrupt event fields.
`define EV_SEL_CHANGE       0
`define EV_FAULT_A          1
`define EV_FAULT_B          2
`define EV_OVERTEMP         3
`define EV_W                4

// Control register: bit 0 lets software mask the whole switch off.
`define CTL_SW_DISABLE      0
`define CTL_RESET           32'h0000_0000

`endif

// ==== core/power_mux_ctrl.v ====
// Implementation choices: register access over APB and the register addresses.
`include "power_mux_map.vh"
`timescale 1ns/1ps
`default_nettype none

// Port groups, top to bottom:
// - APB register slave on pclk, with zero wait states.
// - Two enable pins from the system controller; these arrive from
//   another domain and are synchronised before use.
// - Comparator levels (undervoltage, higher input, current-limit onset,
//   overtemperature); they are taken as already on pclk.
// - Switch and regulation drives for the two analogue channels.
// - Four open-drain status pins, each as a level and an output enable.
//   The level is always low, so oe high pulls the pin down.
// - Open-drain pins need pull-ups outside, ideally to their own input.
// - One level interrupt to the controller.
// The 10 us and 5 ms intervals are counted in pclk cycles; a change of
// clock rate needs the figures in the map header to follow it.

module power_mux_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        select_ctl_a,
  input  wire        select_ctl_b,
  input  wire        uv_ok_a,
  input  wire        uv_ok_b,
  input  wire        a_higher,
  input  wire        limit_onset_a,
  input  wire        limit_onset_b,
  input  wire        overtemp,
  output reg         switch_on_a,
  output reg         switch_on_b,
  output reg         regulate_a,
  output reg         regulate_b,
  output reg         health_flag_a_n,
  output reg         health_flag_a_oe,
  output reg         health_flag_b_n,
  output reg         health_flag_b_oe,
  output reg         chan_a_active_n,
  output reg         chan_a_active_oe,
  output reg         chan_b_active_n,
  output reg         chan_b_active_oe,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // Enables are pins from another domain; two flops before any use.
  // Reset value 00 matches an idle controller, so no false edge is seen
  // after reset and the settle timer stays quiet.
  reg [1:0] en_meta;
  reg [1:0] en_sync;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_meta <= 2'b00;
      en_sync <= 2'b00;
    end else begin
      en_meta <= {select_ctl_a, select_ctl_b};
      en_sync <= en_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable settle timer.

  // Reset value 00 is automatic mode, so start-up routes the higher input.
  reg  [1:0]  en_seen;
  reg  [1:0]  mode;
  reg  [10:0] settle_cnt;
  wire        en_moved = (en_sync != en_seen);

  // Reload value of the settle count, sized to the counter on purpose.
  // Eleven bits hold up to 2047 cycles, which leaves room for a slower
  // clock but not for a settle time above about 20 us at this rate.
  localparam [10:0] SETTLE_LOAD = `SETTLE_CYC;

  // Each edge restarts the wait, so skewed enable edges never leak a mode.
  // Limitation: an enable that toggles faster than the settle time keeps
  // restarting the wait, so the old mode stands until the pins go quiet.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_seen    <= 2'b00;
      mode       <= `MODE_AUTO;
      settle_cnt <= 11'h000;
    end else begin
      en_seen <= en_sync;
      if (en_moved) begin
        settle_cnt <= SETTLE_LOAD;
      end else if (settle_cnt != 11'h000) begin
        settle_cnt <= settle_cnt - 11'h001;
        if (settle_cnt == 11'h001) begin
          // The code that stood through the whole wait is the one taken.
          mode <= en_seen;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current-limit filters, one per channel.

  // Up/down integrator: climbs while limiting, falls otherwise. It reaches
  // the trip level after 5 ms solid, or slowly when duty exceeds one half,
  // and falls back only after 5 ms clear or under half duty.
  // The count saturates at both ends, so a long fault or a long quiet
  // spell can never wrap it round.
  function [`FILTER_W-1:0] filt_step;
    input [`FILTER_W-1:0] cnt;
    input                 lim;
    begin
      if (lim && cnt != `FILTER_CYC)
        filt_step = cnt + 20'h00001;
      else if (!lim && cnt != 20'h00000)
        filt_step = cnt - 20'h00001;
      else
        filt_step = cnt;
    end
  endfunction

  reg  [`FILTER_W-1:0] filt_cnt [0:1];
  reg  [1:0]           lim_flag;
  wire [1:0]           lim_in = {limit_onset_b, limit_onset_a};

  // One filter per channel; index 0 is channel A and index 1 channel B.
  // The flag has hysteresis: it sets only at the full count and clears
  // only at zero, so a duty cycle close to one half cannot chatter it.
  // Limitation: under a duty just above one half the climb is slow, and
  // the flag may take many times 5 ms to set.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_cnt[gi] <= 20'h00000;
          lim_flag[gi] <= 1'b0;
        end else begin
          filt_cnt[gi] <= filt_step(filt_cnt[gi], lim_in[gi]);
          if (filt_cnt[gi] == `FILTER_CYC)
            lim_flag[gi] <= 1'b1;
          else if (filt_cnt[gi] == 20'h00000)
            lim_flag[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Channel selection.

  // Software disable sits in the control register and overrides all
  // modes; it comes up cleared so the block works without any writes.
  reg  [31:0] control;
  reg         next_on_a;
  reg         next_on_b;
  wire        any_limit = limit_onset_a | limit_onset_b;

  // Auto mode keeps its present channel while limiting, since swapping onto
  // the other supply under heavy load could oscillate between the two.
  // The choice is made from the settled mode and this cycle's comparator
  // levels; the output flops below hold it, so the switches move one
  // cycle after an input changes. Forced modes ignore the limit state,
  // which is how a manual change still goes through while limiting.
  always @* begin
    next_on_a = 1'b0;
    next_on_b = 1'b0;
    case (mode)
      `MODE_AUTO: begin
        if (any_limit && (switch_on_a || switch_on_b)) begin
          next_on_a = switch_on_a & uv_ok_a;
          next_on_b = switch_on_b & uv_ok_b;
        end else if (uv_ok_a && (a_higher || !uv_ok_b)) begin
          next_on_a = 1'b1;
        end else if (uv_ok_b) begin
          next_on_b = 1'b1;
        end
      end
      `MODE_FORCE_A: next_on_a = uv_ok_a;
      `MODE_FORCE_B: next_on_b = uv_ok_b;
      `MODE_NONE: begin
        next_on_a = 1'b0;
        next_on_b = 1'b0;
      end
      default: begin
        next_on_a = 1'b0;
        next_on_b = 1'b0;
      end
    endcase
    // Both under lockout, overtemperature or software disable: all off.
    if (overtemp || control[`CTL_SW_DISABLE] || (!uv_ok_a && !uv_ok_b)) begin
      next_on_a = 1'b0;
      next_on_b = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch drives and open-drain status pins.

  // Pins drive low (oe high) for active; release otherwise. A channel with
  // no input has no supply for its pins, so they stay released.
  // Reset leaves every pin released and both switches open, which is the
  // safe state while the comparators are still settling.
  // The active-selection pins follow the next value, so they change on the
  // same edge as the switches and never report a stale channel.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_on_a      <= 1'b0;
      switch_on_b      <= 1'b0;
      regulate_a       <= 1'b0;
      regulate_b       <= 1'b0;
      health_flag_a_n  <= 1'b0;
      health_flag_a_oe <= 1'b0;
      health_flag_b_n  <= 1'b0;
      health_flag_b_oe <= 1'b0;
      chan_a_active_n  <= 1'b0;
      chan_a_active_oe <= 1'b0;
      chan_b_active_n  <= 1'b0;
      chan_b_active_oe <= 1'b0;
    end else begin
      switch_on_a      <= next_on_a;
      switch_on_b      <= next_on_b;
      // Regulation is asked only while the channel stays closed.
      regulate_a       <= limit_onset_a & next_on_a;
      regulate_b       <= limit_onset_b & next_on_b;
      health_flag_a_n  <= 1'b0;
      health_flag_b_n  <= 1'b0;
      chan_a_active_n  <= 1'b0;
      chan_b_active_n  <= 1'b0;
      health_flag_a_oe <= uv_ok_a & (overtemp | lim_flag[0]);
      health_flag_b_oe <= uv_ok_b & (overtemp | lim_flag[1]);
      chan_a_active_oe <= next_on_a;
      chan_b_active_oe <= next_on_b;
    end
  end

  // Undervoltage shows as released health: pull-up to that input reads low
  // once the input collapses, which is how presence is monitored.
  // rely on that outside pull-up.

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events.

  // Events are any change of the selection word and rising edges of each limit flag and
  // of overtemperature. Software clears a status bit by writing a one to
  // the clear register; the enable register masks the interrupt only, so
  // a masked event still shows in the status word.
  // The interrupt is computed from the next status value, so it rises on
  // the same edge as the status bit.
  reg  [`EV_W-1:0] irq_status;
  reg  [`EV_W-1:0] irq_enable;
  reg  [1:0]       prev_sel;
  reg  [1:0]       prev_lim;
  reg              prev_ot;
  wire             wr_en = psel & penable & pwrite;
  wire             rd_en = psel & penable & ~pwrite;
  wire [`EV_W-1:0] clr = (wr_en && paddr == `REG_IRQ_CLEAR) ? pwdata[`EV_W-1:0]
                                                            : 4'h0;
  wire [`EV_W-1:0] events = {overtemp & ~prev_ot,
                             lim_flag[1] & ~prev_lim[1],
                             lim_flag[0] & ~prev_lim[0],
                             prev_sel != {switch_on_b, switch_on_a}};

  // Set wins over a clear in the same cycle so no event is lost.
  // The previous-value flops restart from zero with reset, so a channel
  // that closes just after reset counts as a selection change.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 4'h0;
      prev_sel   <= 2'b00;
      prev_lim   <= 2'b00;
      prev_ot    <= 1'b0;
      irq        <= 1'b0;
    end else begin
      prev_sel   <= {switch_on_b, switch_on_a};
      prev_lim   <= lim_flag;
      prev_ot    <= overtemp;
      irq_status <= (irq_status & ~clr) | events;
      irq        <= |(((irq_status & ~clr) | events) & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped addresses give pslverr.

  // Register map, all word aligned:
  //   status      read-only view of switches, health, limit flags, mode;
  //   irq status  sticky event bits, read-only;
  //   irq enable  read-write mask for the interrupt;
  //   irq clear   write-only, a one clears the matching status bit;
  //   control     bit 0 opens both switches for as long as it is set.
  // Writes to a read-only register are ignored without an error; only an
  // unmapped address answers with pslverr.
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `REG_STATUS) || (a == `REG_IRQ_STATUS) ||
               (a == `REG_IRQ_ENABLE) || (a == `REG_IRQ_CLEAR) ||
               (a == `REG_CONTROL);
    end
  endfunction

  // Read data is chosen combinationally and caught in the setup cycle,
  // so it stands in the access cycle together with pready.
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      `REG_STATUS: begin
        next_rdata[`ST_SEL_A]    = switch_on_a;
        next_rdata[`ST_SEL_B]    = switch_on_b;
        next_rdata[`ST_HEALTH_A] = health_flag_a_oe;
        next_rdata[`ST_HEALTH_B] = health_flag_b_oe;
        next_rdata[`ST_OVERTEMP] = overtemp;
        next_rdata[`ST_LIMIT_A]  = lim_flag[0];
        next_rdata[`ST_LIMIT_B]  = lim_flag[1];
        next_rdata[`ST_MODE_HI:`ST_MODE_LO] = mode;
      end
      `REG_IRQ_STATUS: next_rdata[`EV_W-1:0] = irq_status;
      `REG_IRQ_ENABLE: next_rdata[`EV_W-1:0] = irq_enable;
      `REG_CONTROL:    next_rdata = control;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // Ready rises in the first access cycle; a held penable after that edge
  // is no new transfer; one starts only in a cycle with penable low and psel high.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq_enable <= 4'h0;
      control    <= `CTL_RESET;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (psel && !penable && !pwrite)
        prdata <= next_rdata;
      if (wr_en && pready && paddr == `REG_IRQ_ENABLE)
        irq_enable <= pwdata[`EV_W-1:0];
      if (wr_en && pready && paddr == `REG_CONTROL)
        control <= {31'h0000_0000, pwdata[`CTL_SW_DISABLE]};
    end
  end

endmodule // power_mux_ctrl

`default_nettype wire

// ==== dv/pmux_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the power mux control.
module pmux_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic uv_ok_a,
  input wire logic uv_ok_b,
  input wire logic limit_onset_a,
  input wire logic overtemp,
  input wire logic switch_on_a,
  input wire logic switch_on_b,
  input wire logic regulate_a,
  input wire logic health_flag_a_oe,
  input wire logic health_flag_b_oe,
  input wire logic chan_a_active_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Three-cycle runs cover the single output register with margin; comparator levels have no input stage.
  AST_OT_OFF: assert property (overtemp[*3] |-> !switch_on_a && !switch_on_b)
    else $error("switch closed in overtemp");
  AST_OT_HA: assert property ((overtemp && uv_ok_a)[*3] |-> health_flag_a_oe)
    else $error("health a not low in overtemp");
  AST_OT_HB: assert property ((overtemp && uv_ok_b)[*3] |-> health_flag_b_oe)
    else $error("health b not low in overtemp");
  AST_UV_BOTH: assert property ((!uv_ok_a && !uv_ok_b)[*3] |-> !switch_on_a && !switch_on_b)
    else $error("switch closed with both inputs low");
  AST_UV_A: assert property ((!uv_ok_a)[*3] |-> !switch_on_a)
    else $error("switch a closed below lockout");
  AST_REG_A: assert property ((limit_onset_a && switch_on_a && !overtemp)[*3] |-> regulate_a)
    else $error("no regulation at limit onset");
  AST_IND_ON: assert property ($rose(switch_on_a) |-> ##[0:1] chan_a_active_oe)
    else $error("a indicator not driven");
  AST_IND_OFF: assert property ($fell(switch_on_a) |-> ##[0:1] !chan_a_active_oe)
    else $error("a indicator not released");
endmodule // pmux_monitor
bind power_mux_ctrl pmux_monitor u_pmux_monitor (.*);
`default_nettype wire

// ==== dv/pmux_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// System controller: drives the enables and pulls the open-drain flags up.
module pmux_host (
  input  wire logic       pclk,
  input  wire logic [1:0] code,
  input  wire logic       oe_a,
  input  wire logic       oe_b,
  output var  logic       select_ctl_a,
  output var  logic       select_ctl_b,
  output wire logic       pin_a,
  output wire logic       pin_b
);
  logic b_q;
  initial {select_ctl_a, select_ctl_b, b_q} = 3'h0;
  // B trails A by a cycle, the skew the settle delay must absorb.
  always @(posedge pclk) begin
    select_ctl_a <= code[1];
    b_q <= code[0];
    select_ctl_b <= b_q;
  end
  // Pull-ups make a released flag read high.
  assign pin_a = oe_a ? 1'h0 : 1'h1;
  assign pin_b = oe_b ? 1'h0 : 1'h1;
endmodule // pmux_host
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "power_mux_map.vh"
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, probe = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, select_ctl_a, select_ctl_b, pin_a, pin_b, irq;
  logic        uv_ok_a = 1, uv_ok_b = 1, a_higher = 1, limit_onset_a = 0, overtemp = 0;
  logic        limit_onset_b = 0, switch_on_a, switch_on_b, regulate_a, regulate_b;
  logic        health_flag_a_n, health_flag_a_oe, health_flag_b_n, health_flag_b_oe;
  logic        chan_a_active_n, chan_a_active_oe, chan_b_active_n, chan_b_active_oe;
  logic [1:0]  code = 0, old = 0, sel [4] = '{2'h1, 2'h0, 2'h1, 2'h2};
  logic [7:0]  lf = 8'h08;
  int          bad_count = 0, samples_checked = 0;
  string       q_nm[$];
  logic [32:0] q_e[$], q_m[$];

  power_mux_ctrl u_power_mux_ctrl (.*);
  pmux_host u_pmux_host (.pclk(pclk), .code(code), .oe_a(health_flag_a_oe),
    .oe_b(health_flag_b_oe), .select_ctl_a(select_ctl_a), .select_ctl_b(select_ctl_b),
    .pin_a(pin_a), .pin_b(pin_b));

  initial forever #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] nx(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic wt(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic cmp(string nm, logic [32:0] e, logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic note(string nm, logic [32:0] e, logic [32:0] m);
    q_nm.push_back(nm);
    q_e.push_back(e);
    q_m.push_back(m);
  endtask
  // Request held until pready is seen high at a rising edge.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(string nm, logic [11:0] a, logic [32:0] e, logic [32:0] m);
    note(nm, e, m);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic pk(string nm, logic [32:0] e, logic [32:0] m);
    note(nm, e, m);
    probe <= 1'h1;
    @(posedge pclk) probe <= 1'h0;
    @(posedge pclk);
  endtask
  // Enables go through the host, then two syncs and the settle count.
  task automatic md(logic [1:0] c);
    code <= c;
    wt(1100);
  endtask
  task test_done;
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Oldest note meets the next read answer or pin probe.
  always @(posedge pclk)
    if (probe || (psel && penable && pready === 1'h1 && !pwrite))
      cmp(q_nm.pop_front(), q_e.pop_front(),
          q_m.pop_front() & (probe ? {22'h0, health_flag_a_n, health_flag_b_n,
            chan_a_active_n, chan_b_active_n, chan_a_active_oe, chan_b_active_oe,
            regulate_a, regulate_b, irq, pin_a, pin_b} : {pslverr, prdata}));

  initial begin
    wt(40000);
    bad_count++;
    test_done();
  end

  initial begin
    wt(12);
    presetn <= 1'h1;
    wt(1100);
    rd("ien", `REG_IRQ_ENABLE, 33'h0, 33'h1_ffff_ffff);
    rd("ctl", `REG_CONTROL, 33'h0, 33'h1_ffff_ffff);
    rd("unmapped", 12'h020, 33'h1_0000_0000, 33'h1_ffff_ffff);
    rd("start", `REG_STATUS, 33'h1, 33'h303);
    // Halfway through the settle the previous choice must still stand.
    for (int i = 3; i >= 0; i--) begin
      code <= i[1:0];
      wt(500);
      rd("hold", `REG_STATUS, {23'h0, old, 6'h0, sel[old]}, 33'h303);
      wt(600);
      rd("mode", `REG_STATUS, {23'h0, i[1:0], 6'h0, sel[i]}, 33'h303);
      old = i[1:0];
    end
    repeat (6) begin
      lf = nx(lf);
      a_higher <= lf[0];
      wt(4);
      rd("auto", `REG_STATUS, lf[0] ? 33'h1 : 33'h2, 33'h3);
    end
    a_higher <= 1'h1;
    uv_ok_a <= 1'h0;
    wt(4);
    rd("uv a", `REG_STATUS, 33'h2, 33'h3);
    uv_ok_b <= 1'h0;
    wt(4);
    rd("uv both", `REG_STATUS, 33'h0, 33'h3);
    uv_ok_b <= 1'h1;
    md(2'h2);
    rd("force a uv", `REG_STATUS, 33'h0, 33'h3);
    uv_ok_a <= 1'h1;
    wt(4);
    rd("force a", `REG_STATUS, 33'h1, 33'h3);
    md(2'h0);
    limit_onset_a <= 1'h1;
    a_higher <= 1'h0;
    wt(10);
    rd("limit hold", `REG_STATUS, 33'h1, 33'h3);
    pk("filter", 33'h53, 33'h7ff);
    md(2'h3);
    rd("limit manual", `REG_STATUS, 33'h2, 33'h3);
    limit_onset_a <= 1'h0;
    md(2'h0);
    apb(1'h1, `REG_IRQ_ENABLE, 32'h8);
    overtemp <= 1'h1;
    wt(4);
    rd("ot", `REG_STATUS, 33'h1c, 33'h1f);
    pk("ot pins", 33'h4, 33'h7ff);
    overtemp <= 1'h0;
    apb(1'h1, `REG_IRQ_ENABLE, 32'h0);
    pk("masked", 33'h0, 33'h4);
    apb(1'h1, `REG_IRQ_ENABLE, 32'h8);
    pk("irq", 33'h4, 33'h4);
    apb(1'h1, `REG_IRQ_CLEAR, 32'h8);
    pk("cleared", 33'h0, 33'h4);
    rd("irq st", `REG_IRQ_STATUS, 33'h0, 33'h8);
    test_done();
  end
endmodule // tb
`default_nettype wire
